/* ssc_decoder.sv */
// Purpose: Decodes serial config and mode words and runs the channel sequencer.
// Assumes: The link clock is unrelated to i_sys_clk; words are 16 bits.
// Notes:   Conversion timing is a stand-in for the analog engine.
//
// Operation
// - Select field 10101 writes low scan register.
// - Bits 10..3 include channels 7..0; reset zero.
// - Select field 10110 writes sequence length register.
// - Length field is bits 10..3, default zero.
// - Sequence runs length plus one conversions.
// - First bit one means configuration write.
// - First bit zero means mode-control command.
// - Mode during sequence waits, runs next CS fall.
// - Config during sequence keeps active scan mode.
// - Config during sequence invalidates data until mode.

module ssc_decoder
	import ssc_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_sclk,
	input  wire logic        i_cs_n,
	input  wire logic        i_din,
	output logic [7:0]       o_scan_select,
	output logic [7:0]       o_sequence_length_field,
	output logic [7:0]       o_active_scan,
	output logic [7:0]       o_active_length,
	output logic             o_seq_running,
	output logic             o_conv_start,
	output logic [7:0]       o_conv_index,
	output logic [15:0]      o_mode_cmd,
	output logic             o_mode_exec,
	output logic             o_data_valid
);

	// ----------------------------------------------------------------
	// Link side receiver
	// ----------------------------------------------------------------
	logic [15:0] link_word;         // Word held in the link domain.
	logic        link_toggle;       // Flips once per complete word.

	ssc_link_rx u_rx (
		.i_sclk        (i_sclk),
		.i_rst_n       (i_rst_n),
		.i_cs_n        (i_cs_n),
		.i_din         (i_din),
		.o_word        (link_word),
		.o_word_toggle (link_toggle)
	);

	// ----------------------------------------------------------------
	// Clock crossing
	// ----------------------------------------------------------------
	logic tog_meta;                 // First stage, read only by tog_sync.
	logic tog_sync;                 // Synchronised toggle.
	logic tog_prev;                 // Toggle one cycle ago.
	logic cs_meta;                  // First stage, read only by cs_sync.
	logic cs_sync;                  // Synchronised chip select.
	logic cs_prev;                  // Chip select one cycle ago.
	logic take;                     // A new word is ready this cycle.
	logic cs_fall;                  // Chip select went low.
	ssc_kind_type kind;             // Sort of the new word.

	// The word is copied on the toggle event only; it was stable in the
	// link domain for many system cycles after the toggle got here.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_prev <= 1'b0;
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_prev  <= 1'b1;
		end else begin
			tog_meta <= link_toggle;
			tog_sync <= tog_meta;
			tog_prev <= tog_sync;
			cs_meta  <= i_cs_n;
			cs_sync  <= cs_meta;
			cs_prev  <= cs_sync;
		end
	end

	assign take    = tog_sync ^ tog_prev;
	assign cs_fall = cs_prev & ~cs_sync;
	// The first bit tells config from mode; bits 2..0 of a config word are never looked at.
	assign kind    = ssc_word_kind(link_word);

	// ----------------------------------------------------------------
	// Registers and sequencer
	// ----------------------------------------------------------------
	ssc_state_type state;           // Sequencer state.
	ssc_state_type next_state;      // Next sequencer state.
	logic [7:0]  timer;             // Cycles left in this conversion.
	logic [7:0]  next_timer;        // Next timer.
	logic        pending;           // A mode command waits for CS fall.
	logic        next_pending;      // Next pending flag.
	logic [15:0] pend_word;         // The waiting mode command.
	logic [15:0] next_pend_word;    // Next waiting command.
	logic [7:0]  next_scan;         // Next low scan register.
	logic [7:0]  next_len;          // Next length register.
	logic [7:0]  next_active_scan;  // Next active scan set.
	logic [7:0]  next_active_len;   // Next active length.
	logic        next_running;      // Next running flag.
	logic        next_start;        // Next conversion start pulse.
	logic [7:0]  next_index;        // Next conversion index.
	logic [15:0] next_cmd;          // Next executed command.
	logic        next_exec;         // Next execute pulse.
	logic        next_valid;        // Next data valid flag.
	logic        go;                // Execute a mode command now.
	logic [15:0] go_word;           // The command to execute.

	// Next values for the whole register and sequencer group.
	always_comb begin
		next_state       = state;
		next_timer       = timer;
		next_pending     = pending;
		next_pend_word   = pend_word;
		next_scan        = o_scan_select;
		next_len         = o_sequence_length_field;
		next_active_scan = o_active_scan;
		next_active_len  = o_active_length;
		next_running     = o_seq_running;
		next_start       = 1'b0;
		next_index       = o_conv_index;
		next_cmd         = o_mode_cmd;
		next_exec        = 1'b0;
		next_valid       = o_data_valid;
		go               = 1'b0;
		go_word          = link_word;
		case (state)
			ST_IDLE: begin
				// Nothing running, so a mode command acts at once.
				if (take && kind == KIND_MODE) begin
					go = 1'b1;
				end
			end
			ST_CONVERT: begin
				// A command is noted first. One that lands on the last timer
				// cycle then still waits, instead of being lost to idle.
				if (take && kind == KIND_MODE) begin
					next_pending   = 1'b1;
					next_pend_word = link_word;
				end
				if (timer == 8'h00) begin
					// The conversion in progress always completes first.
					if (next_pending) begin
						next_state   = ST_WAIT_CS;
						next_running = 1'b0;
					end else if (o_conv_index == o_active_length) begin
						next_state   = ST_IDLE;
						next_running = 1'b0;
					end else begin
						next_index = o_conv_index + 8'h01;
						next_timer = CONV_LOAD;
						next_start = 1'b1;
					end
				end else begin
					next_timer = timer - 8'h01;
				end
			end
			ST_WAIT_CS: begin
				if (cs_fall) begin
					go           = 1'b1;
					go_word      = pend_word;
					next_pending = 1'b0;
				end
				// A newer command replaces the waiting one. One that lands with
				// the frame start itself keeps waiting for the next frame, so
				// setting the flag wins over clearing it.
				if (take && kind == KIND_MODE) begin
					next_pending   = 1'b1;
					next_pend_word = link_word;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Starting a command snapshots the scan set and length, so later
		// config writes cannot disturb a sequence already under way.
		if (go) begin
			next_cmd         = go_word;
			next_exec        = 1'b1;
			next_valid       = 1'b1;
			next_state       = ST_CONVERT;
			next_running     = 1'b1;
			next_index       = 8'h00;
			next_timer       = CONV_LOAD;
			next_start       = 1'b1;
			next_active_scan = o_scan_select;
			next_active_len  = o_sequence_length_field;
		end
		// Config handling comes last so an invalidation wins in a tie.
		if (take && kind == KIND_SCAN) begin
			next_scan = link_word[FIELD_HI:FIELD_LO];
		end
		if (take && kind == KIND_SEQ) begin
			next_len = link_word[FIELD_HI:FIELD_LO];
		end
		if (take && kind != KIND_MODE && state == ST_CONVERT) begin
			next_valid = 1'b0;
		end
	end

	// Registers of the group; every output comes from here.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state           <= ST_IDLE;
			timer           <= 8'h00;
			pending         <= 1'b0;
			pend_word       <= CMD_RESET;
			o_scan_select   <= SCAN_RESET;
			o_sequence_length_field    <= LEN_RESET;
			o_active_scan   <= SCAN_RESET;
			o_active_length <= LEN_RESET;
			o_seq_running   <= 1'b0;
			o_conv_start    <= 1'b0;
			o_conv_index    <= 8'h00;
			o_mode_cmd      <= CMD_RESET;
			o_mode_exec     <= 1'b0;
			o_data_valid    <= 1'b0;
		end else begin
			state           <= next_state;
			timer           <= next_timer;
			pending         <= next_pending;
			pend_word       <= next_pend_word;
			o_scan_select   <= next_scan;
			o_sequence_length_field    <= next_len;
			o_active_scan   <= next_active_scan;
			o_active_length <= next_active_len;
			o_seq_running   <= next_running;
			o_conv_start    <= next_start;
			o_conv_index    <= next_index;
			o_mode_cmd      <= next_cmd;
			o_mode_exec     <= next_exec;
			o_data_valid    <= next_valid;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	// Register writes: each select code reaches its own register only.
	scan_write_a: assert property (
		take && kind == KIND_SCAN |=> o_scan_select == $past(link_word[FIELD_HI:FIELD_LO]))
		else $error("Low scan register did not take the written field.");

	seq_write_a: assert property (
		take && kind == KIND_SEQ |=> o_sequence_length_field == $past(link_word[FIELD_HI:FIELD_LO]))
		else $error("Length register did not take the written field.");

	scan_other_a: assert property (
		take && kind != KIND_SCAN |=> $stable(o_scan_select))
		else $error("Low scan register changed on another word.");

	seq_keep_a: assert property (
		take && kind != KIND_SEQ |=> $stable(o_sequence_length_field))
		else $error("Length register changed on another word.");

	// Sequencer: length plus one conversions from a snapshot of the registers.
	seq_count_a: assert property (
		o_seq_running |-> o_conv_index <= o_active_length)
		else $error("Conversion index passed the sequence length.");

	seq_end_a: assert property (
		$fell(o_seq_running) && !pending |-> $past(o_conv_index) == $past(o_active_length))
		else $error("Sequence ended before length plus one conversions.");

	exec_start_a: assert property (
		o_mode_exec |-> o_conv_start && o_conv_index == 8'h00)
		else $error("Executed command did not start the first conversion.");

	snap_take_a: assert property (
		o_mode_exec |-> o_active_length == $past(o_sequence_length_field)
			&& o_active_scan == $past(o_scan_select))
		else $error("Executed command did not snapshot the registers.");

	// Mode commands: at once when idle, otherwise at the next frame start.
	mode_idle_a: assert property (
		state == ST_IDLE && take && kind == KIND_MODE |=> o_mode_exec
			&& o_mode_cmd == $past(link_word))
		else $error("Mode command in idle did not run at once.");

	cfg_nostart_a: assert property (
		take && kind != KIND_MODE && state != ST_WAIT_CS |=> !o_mode_exec)
		else $error("Configuration word started a command.");

	mode_wait_a: assert property (
		state == ST_CONVERT && timer != 8'h00 && take && kind == KIND_MODE
			|=> !o_mode_exec ##0 pending)
		else $error("Mode command did not wait for the running conversion.");

	wait_stop_a: assert property (
		state == ST_WAIT_CS |-> !o_seq_running)
		else $error("Sequence kept running while a command waited.");

	mode_cs_a: assert property (
		state == ST_WAIT_CS && cs_fall |=> o_mode_exec && o_mode_cmd == $past(pend_word))
		else $error("Waiting command did not run at chip select fall.");

	// Config during a sequence keeps the scan in use but spoils the data.
	cfg_keep_a: assert property (
		state == ST_CONVERT && take && kind != KIND_MODE
			|=> $stable(o_active_scan) && !o_data_valid)
		else $error("Config during sequence changed scan or kept data valid.");

	valid_back_a: assert property (
		o_mode_exec |-> o_data_valid ##1 o_seq_running)
		else $error("Executed command did not restore valid data.");

endmodule

/* ssc_decoder_tb.sv */
// Purpose: Self-checking bench for the scan and sequence config decoder.
// Assumes: Sys clock 25 MHz; the host model runs its own unrelated link clock.
// Notes:   Expectations come from the field layout and the length-plus-one law.

`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin \
	n_mismatch++; $display("CHECK FAILED t=%0t %s", $time, msg); end end

module ssc_decoder_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ssc_pkg::*;

	logic        i_sys_clk;                     // System clock.
	logic        i_rst_n;                       // Active-low reset.
	logic        sclk, cs_n, din;               // Link lines from the host.
	logic [7:0]  scan, len, ascan, alen, idx;   // Register and snapshot outputs.
	logic        run, cst, mexec, dval;         // Sequencer status.
	logic [15:0] mcmd;                          // Last executed mode word.
	int          n_mismatch, check_count, seed, n_start, n_exec, i;
	logic [7:0]  d, l, s0;
	logic [15:0] w, w0;

	ssc_host_model host_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));

	ssc_decoder ssc_decoder_i (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_din(din), .o_scan_select(scan), .o_sequence_length_field(len), .o_active_scan(ascan),
		.o_active_length(alen), .o_seq_running(run), .o_conv_start(cst),
		.o_conv_index(idx), .o_mode_cmd(mcmd), .o_mode_exec(mexec), .o_data_valid(dval)
	);

	// ------------------------------------------------------------
	// Clock and conversion counter
	// ------------------------------------------------------------
	initial i_sys_clk = 1'b0;
	always #20 i_sys_clk = ~i_sys_clk;

	// Counts conversion starts so sequence lengths can be judged.
	always @(posedge i_sys_clk) begin
		if (cst === 1'b1) begin
			n_start++;
		end
		// Executed commands, so a waiting one can be shown not to run early.
		if (mexec === 1'b1) begin
			n_exec++;
		end
	end

	// Expected conversions for a length field: straight binary plus one.
	function automatic int exp_convs(input logic [7:0] f);
		return int'(f) + 1;
	endfunction

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Config write; the low three bits are random since they must not matter.
	task automatic cfg(input logic [4:0] sel, input logic [7:0] f);
		host_i.send({sel, f, 3'($random(seed))}, 16);
		repeat (2) @(posedge i_sys_clk);
	endtask

	// Mode word with bit 15 clear and random remaining bits.
	task automatic mode(output logic [15:0] m);
		m = {1'b0, 15'($random(seed))};
		host_i.send(m, 16);
	endtask

	// Bounded wait for the sequencer to stop; a hang ends the run.
	task automatic wait_idle(input int lim);
		int k;
		for (k = 0; k < lim && run !== 1'b0; k++) begin
			@(posedge i_sys_clk);
		end
		if (run !== 1'b0) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t sequencer did not stop", $time);
			test_done();
		end
		@(posedge i_sys_clk);
	endtask

	// Cuts a hang short at 2 ms, well above the length of a normal run.
	initial begin
		#2ms;
		n_mismatch++;
		$display("CHECK FAILED t=%0t run timed out", $time);
		test_done();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 94;
		n_start = 0;
		n_exec = 0;
		i_rst_n = 1'b0;
		repeat (4) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		`CHK(scan, SCAN_RESET, "scan reset")
		`CHK(len, LEN_RESET, "length reset")
		`CHK(dval, 1'b0, "valid reset")
		`CHK(mcmd, CMD_RESET, "command reset")
		$display("test reset done");

		// Register writes, a foreign select code and a short frame.
		for (i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hff : 8'($random(seed));
			l = (i == 1) ? 8'hff : 8'($random(seed));
			cfg(SEL_SCAN_LOW, d);
			`CHK(scan, d, "scan write")
			cfg(SEL_SEQ_LEN, l);
			`CHK(len, l, "length write")
			`CHK(scan, d, "scan kept on length write")
			cfg(5'h14, ~d);
			`CHK(scan, d, "foreign select ignored")
			host_i.send({SEL_SCAN_LOW, ~d, 3'h0}, 10);
			`CHK(scan, d, "short frame ignored")
		end
		$display("test registers done");

		// Sequence lengths at both ends of the field and at random.
		for (i = 0; i < 4; i++) begin
			l = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hff : 8'($random(seed));
			s0 = 8'($random(seed));
			cfg(SEL_SEQ_LEN, l);
			cfg(SEL_SCAN_LOW, s0);
			n_start = 0;
			n_exec = 0;
			mode(w);
			wait_idle(4000);
			`CHK(n_start, exp_convs(l), "conversion count")
			`CHK(n_exec, 1, "one command executed")
			`CHK(idx, l, "last conversion index")
			`CHK(alen, l, "active length")
			`CHK(ascan, s0, "active scan")
			`CHK(mcmd, w, "mode word taken")
			`CHK(dval, 1'b1, "data valid after mode")
		end
		$display("test lengths done");

		// Config during a sequence keeps the running scan, spoils data.
		cfg(SEL_SEQ_LEN, 8'h0f);
		mode(w);
		d = ~s0;
		cfg(SEL_SCAN_LOW, d);
		`CHK(run, 1'b1, "still running")
		`CHK(ascan, s0, "old scan kept")
		`CHK(scan, d, "scan register updated")
		`CHK(dval, 1'b0, "data invalid")
		wait_idle(400);
		`CHK(dval, 1'b0, "data stays invalid")
		mode(w);
		`CHK(dval, 1'b1, "data valid again")
		`CHK(ascan, d, "new scan active")
		wait_idle(400);
		$display("test config in sequence done");

		// Mode during a long sequence waits for the next frame start.
		// The second command stops the sequence after the conversion in
		// progress; the frame start of the next word then runs it.
		cfg(SEL_SEQ_LEN, 8'hff);
		mode(w0);
		n_exec = 0;
		mode(w);
		wait_idle(40);
		`CHK(run, 1'b0, "sequence stopped")
		`CHK(mcmd, w0, "first mode still shown")
		`CHK(n_exec, 0, "pending mode not run")
		cfg(SEL_SEQ_LEN, 8'h00);
		`CHK(mcmd, w, "pending mode runs at frame start")
		`CHK(n_exec, 1, "pending mode run once")
		`CHK(run, 1'b1, "pending mode started")
		`CHK(alen, 8'hff, "length taken at frame start")
		`CHK(dval, 1'b0, "config in sequence spoils data")
		wait_idle(4000);
		$display("test mode in sequence done");
		test_done();
	end
endmodule

/* ssc_host_model.sv */
// Purpose: Host serial master that frames 16-bit words onto the decoder link.
// Assumes: Link clock period 125 ns, idle low, running only inside frames.
// Notes:   Data changes on the falling link edge and is held across the rise.

module ssc_host_model (
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_din
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------
	// The link clock stands still between frames.
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_din  = 1'b1;
	end

	// ------------------------------------------------------------
	// Frame driver
	// ------------------------------------------------------------
	// Sends the top nbits of w; fewer than 16 makes a short frame.
	task automatic send(input logic [15:0] w, input int nbits);
		int i;
		#31 o_cs_n = 1'b0;
		for (i = 0; i < nbits; i++) begin
			o_din = w[15 - i];                 // Bit 15 leads, marking config or mode.
			#62.5 o_sclk = 1'b1;
			#62.5 o_sclk = 1'b0;
		end
		#31 o_cs_n = 1'b1;
		// A released line must not keep showing the last bit.
		o_din = ~o_din;
		#250;
	endtask
endmodule

/* ssc_link_rx.sv */
// Purpose: Serial receiver on the link clock; gathers one 16-bit word per frame.
// Assumes: Data sampled on the rising serial clock edge, first bit first.
// Notes:   Bits past the sixteenth in a frame are ignored.

module ssc_link_rx
	import ssc_pkg::*;
(
	input  wire logic        i_sclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_cs_n,
	input  wire logic        i_din,
	output logic [15:0]      o_word,
	output logic             o_word_toggle
);

	// ----------------------------------------------------------------
	// Frame state
	// ----------------------------------------------------------------
	logic [14:0] shift;             // Bits gathered so far.
	logic [4:0]  count;             // Bits taken in this frame.
	logic [14:0] next_shift;        // Next gathered bits.
	logic [4:0]  next_count;        // Next bit count.
	logic [15:0] next_word;         // Next held word.
	logic        next_toggle;       // Next handover toggle.
	logic        frame_clr;         // Clears the frame state outside frames.

	// The serial clock stops between frames, so chip select itself clears
	// the count instead of relying on any edge after the frame.
	assign frame_clr = i_cs_n | ~i_rst_n;

	// Next values for the shifter and the word handed to the system side.
	always_comb begin
		next_shift  = shift;
		next_count  = count;
		next_word   = o_word;
		next_toggle = o_word_toggle;
		if (count < 5'(WORD_BITS)) begin
			next_shift = {shift[13:0], i_din};
			next_count = count + 5'h01;
			if (count == 5'(WORD_BITS - 1)) begin
				// The held word stays stable for a full frame, long enough
				// for the system side to see the toggle and copy it.
				next_word   = {shift, i_din};
				next_toggle = ~o_word_toggle;
			end
		end
	end

	// Frame-bounded registers.
	always_ff @(posedge i_sclk or posedge frame_clr) begin
		if (frame_clr) begin
			shift <= 15'h0000;
			count <= 5'h00;
		end else begin
			shift <= next_shift;
			count <= next_count;
		end
	end

	// Handover registers, kept across frames.
	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_word        <= CMD_RESET;
			o_word_toggle <= 1'b0;
		end else begin
			o_word        <= next_word;
			o_word_toggle <= next_toggle;
		end
	end

endmodule

/* ssc_pkg.sv */
// Purpose: Shared constants and types for the scan sequence config decoder.
// Assumes: 16-bit serial words, most significant bit first.
// Notes:   Word offsets, field positions, register reset values and the conversion cycle count live here.

package ssc_pkg;

	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int         WORD_BITS    = 16;        // Bits in one serial word.
	localparam int         KIND_BIT     = 15;        // First bit: 1 config, 0 mode.
	localparam int         SEL_HI       = 15;        // Register select field top.
	localparam int         SEL_LO       = 11;        // Register select field bottom.
	localparam int         FIELD_HI     = 10;        // Payload field top.
	localparam int         FIELD_LO     = 3;         // Payload field bottom.
	localparam logic [4:0] SEL_SCAN_LOW = 5'h15;     // Selects the low scan register.
	localparam logic [4:0] SEL_SEQ_LEN  = 5'h16;     // Selects the sequence length.

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  SCAN_RESET = 8'h00;      // No channel scanned.
	localparam logic [7:0]  LEN_RESET  = 8'h00;      // One conversion.
	localparam logic [15:0] CMD_RESET  = 16'h0000;   // No mode command seen.

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ  = 25;                // System clock rate.
	localparam int CONV_TIME_NS = 480;               // Time of one conversion.
	// Least time, so round up to whole cycles, never below one.
	localparam int CONV_CYCLES_RAW = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int CONV_CYCLES     = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
	localparam logic [7:0] CONV_LOAD = 8'(CONV_CYCLES - 1);  // Timer reload.

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		KIND_MODE,
		KIND_SCAN,
		KIND_SEQ,
		KIND_OTHER
	} ssc_kind_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_WAIT_CS
	} ssc_state_type;

	// Sorts a received word by its first bit and its select field.
	function automatic ssc_kind_type ssc_word_kind(input logic [15:0] word);
		ssc_kind_type k;
		k = KIND_OTHER;
		if (!word[KIND_BIT]) begin
			k = KIND_MODE;
		end else if (word[SEL_HI:SEL_LO] == SEL_SCAN_LOW) begin
			k = KIND_SCAN;
		end else if (word[SEL_HI:SEL_LO] == SEL_SEQ_LEN) begin
			k = KIND_SEQ;
		end
		return k;
	endfunction

endpackage
